// ===== src/ict_pkg.sv
// Purpose: Shared constants and carrier types for the internal clock generator tuning block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: Offsets are byte addresses

package ict_pkg;

    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_MULT = 8'h04;
    localparam logic [7:0] A_TRIM = 8'h08;
    localparam logic [7:0] A_DIV = 8'h0c;
    localparam logic [7:0] A_STAGE = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;
    localparam logic [7:0] A_IRQS = 8'h18;
    localparam logic [7:0] A_IRQM = 8'h1c;

    // Field positions
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_SLOW_BIT = 1;
    localparam int EV_STABLE = 0;
    localparam int EV_INACT = 1;

    // Values after reset
    localparam logic GEN_ON_RST = 1'b1;
    localparam logic SLOW_RST = 1'b0;
    localparam logic [6:0] MULT_RST = 7'h15;
    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam logic [3:0] DIV_RST = 4'h1;
    localparam logic [7:0] STAGE_RST = 8'h80;

    // Capacitor: fixed units plus trimmed units, 639 in all
    localparam logic [9:0] CAP_FIXED = 10'h180;
    localparam logic [9:0] CAP_RST = 10'h200;

    // Loop filter limits
    localparam logic [7:0] STAGE_MID = 8'h80;
    localparam logic [7:0] STAGE_MAX = 8'hff;
    localparam logic [7:0] STAGE_MIN = 8'h01;
    localparam logic [3:0] DIV_MAX = 4'hf;

    // Cycle counts: base clock edges per correction, oscillator edges per core edge
    localparam logic [2:0] CORR_LAST = 3'h7;
    localparam logic [1:0] CORE_LAST = 2'h3;
    localparam int PER_SHIFT_DEF = 4;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ict_ahb_req_t;

    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } ict_ahb_rsp_t;

    typedef struct packed {
        logic too_fast;
        logic too_slow;
        logic within5;
        logic int_inactive;
    } ict_cmp_t;

    typedef struct packed {
        logic gen_on;
        logic slow_opt;
        logic [6:0] mult;
        logic [7:0] trim;
        logic [3:0] div;
        logic [7:0] stage;
        logic stable;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic rdy;
        logic [31:0] rdata;
        logic [2:0] corr_cnt;
        logic [1:0] clk_ph;
        logic osc_clk;
        logic core_clk;
        logic base_clk;
        logic [9:0] cap;
    } ict_top_st_t;

endpackage

// ===== src/ict_dco.sv
// Purpose: Digitally controlled oscillator model, one tick per half period
// Assumes: Half period in clk cycles is (stage << divider) >> PER_SHIFT
// Notes: The divider and stage are sampled at every reload

`timescale 1ns/10ps

module ict_dco #(
    parameter int PER_SHIFT = 4
)(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic run, // Oscillator running
    input wire logic [3:0] div, // Divider field
    input wire logic [7:0] stage, // Stage field
    output logic tick // One-cycle pulse per half period
);

    typedef struct packed {
        logic [23:0] cnt;
        logic tick;
    } ict_dco_st_t;

    ict_dco_st_t st, next_st;

    always_comb
    begin
        logic [23:0] per;
        per = ({16'h0, stage} << div) >> PER_SHIFT;
        if (per == 24'h0)
        begin
            per = 24'h1;
        end
        next_st = st;
        next_st.tick = 1'b0;
        if (!run)
        begin
            // Restart from the latest fields when enabled again
            next_st.cnt = 24'h0;
        end
        else if (st.cnt == 24'h0)
        begin
            next_st.cnt = per - 24'h1;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt - 24'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    a_dco_halt: assert property (@(posedge clk) disable iff (sys_rst)
        !run |=> !tick) else $error("oscillator ticked while halted");

endmodule

// ===== src/ict_div.sv
// Purpose: Enable divider, one pulse every n input enables
// Assumes: n of zero behaves as one
// Notes: Output pulse lags the enable that completes the count by one cycle

`timescale 1ns/10ps

module ict_div #(
    parameter int W = 7
)(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic run, // Count while high, clear while low
    input wire logic en, // Input enable pulse
    input wire logic [W-1:0] n, // Division ratio
    output logic pulse // One-cycle output pulse
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic pulse;
    } ict_div_st_t;

    ict_div_st_t st, next_st;

    always_comb
    begin
        next_st = st;
        next_st.pulse = 1'b0;
        if (!run)
        begin
            next_st.cnt = '0;
        end
        else if (en)
        begin
            if (n == '0 || st.cnt >= W'(n - 1'b1))
            begin
                next_st.cnt = '0;
                next_st.pulse = 1'b1;
            end
            else
            begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pulse = st.pulse;

    a_div_cause: assert property (@(posedge clk) disable iff (sys_rst)
        pulse |-> $past(en) && $past(run)) else $error("divider pulsed without enable");

endmodule

// ===== src/ict_top.sv
// Purpose: Tuning, trim and low-power control of the internal clock generator
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: Comparator results come from the analog frequency comparator
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.

`timescale 1ns/10ps

module ict_top #(
    parameter int PER_SHIFT = ict_pkg::PER_SHIFT_DEF
)(
    input wire logic clk, // System clock, 50 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire ict_pkg::ict_ahb_req_t ahb_req, // AHB-Lite request
    output ict_pkg::ict_ahb_rsp_t ahb_rsp, // AHB-Lite response
    input wire ict_pkg::ict_cmp_t cmp, // Frequency comparator and monitor
    input wire logic stop_mode, // Stop mode active
    output logic osc_output_clock, // Oscillator clock, internal source
    output logic low_freq_base_clock, // Base clock
    output logic core_output_clock, // Bus clock
    output logic [9:0] cap_units, // Connected capacitor units
    output logic amp_low_drive, // Reduced amplifier drive
    output logic mon_expect_slow, // Monitor expects slow external clock
    output logic internal_gen_stable, // Internal clock stable
    output logic irq // Interrupt, active high level
);

    ict_pkg::ict_top_st_t st, next_st;
    logic running;
    logic dco_tick;
    logic base_tick;

    // Wait mode has no input here: only stop or a cleared gen_on halts the generator
    assign running = st.gen_on && !stop_mode;

    ict_dco #(
        .PER_SHIFT(PER_SHIFT)
    ) u_dco (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(running),
        .div(st.div),
        .stage(st.stage),
        .tick(dco_tick)
    );

    ict_div #(
        .W(7)
    ) u_base (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(running),
        .en(dco_tick),
        .n(st.mult),
        .pulse(base_tick)
    );

    always_comb
    begin
        logic ap;
        logic hit;
        logic [31:0] wd;
        logic [1:0] ev;
        logic [1:0] clr;
        next_st = st;
        wd = ahb_req.hwdata;
        ev = 2'h0;
        clr = 2'h0;
        ap = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
        hit = (ahb_req.haddr[31:8] == 24'h0) && (ahb_req.haddr[1:0] == 2'h0);
        next_st.rdy = 1'b1;
        next_st.wr_pend = ap && ahb_req.hwrite && hit;
        next_st.wr_addr = ahb_req.haddr[7:0];

        // Read data captured in the address phase; unmapped reads give zero
        if (ap && !ahb_req.hwrite)
        begin
            next_st.rdata = 32'h0;
            if (hit)
            begin
                case (ahb_req.haddr[7:0])
                    ict_pkg::A_CTRL:
                    begin
                        next_st.rdata = {30'h0, st.slow_opt, st.gen_on};
                    end
                    ict_pkg::A_MULT:
                    begin
                        next_st.rdata = {25'h0, st.mult};
                    end
                    ict_pkg::A_TRIM:
                    begin
                        next_st.rdata = {24'h0, st.trim};
                    end
                    ict_pkg::A_DIV:
                    begin
                        next_st.rdata = {28'h0, st.div};
                    end
                    ict_pkg::A_STAGE:
                    begin
                        next_st.rdata = {24'h0, st.stage};
                    end
                    ict_pkg::A_STAT:
                    begin
                        next_st.rdata = {30'h0, running, st.stable};
                    end
                    ict_pkg::A_IRQS:
                    begin
                        next_st.rdata = {30'h0, st.irq_stat};
                    end
                    ict_pkg::A_IRQM:
                    begin
                        next_st.rdata = {30'h0, st.irq_mask};
                    end
                    default:
                    begin
                        next_st.rdata = 32'h0;
                    end
                endcase
            end
        end

        // Write data phase
        if (st.wr_pend)
        begin
            case (st.wr_addr)
                ict_pkg::A_CTRL:
                begin
                    next_st.gen_on = wd[ict_pkg::CTRL_ON_BIT];
                    next_st.slow_opt = wd[ict_pkg::CTRL_SLOW_BIT];
                end
                ict_pkg::A_MULT:
                begin
                    next_st.mult = wd[6:0];
                end
                ict_pkg::A_TRIM:
                begin
                    next_st.trim = wd[7:0];
                end
                ict_pkg::A_DIV:
                begin
                    if (!st.gen_on)
                    begin
                        next_st.div = wd[3:0];
                    end
                end
                ict_pkg::A_STAGE:
                begin
                    if (!st.gen_on)
                    begin
                        next_st.stage = wd[7:0];
                    end
                end
                ict_pkg::A_IRQS:
                begin
                    clr = wd[1:0];
                end
                ict_pkg::A_IRQM:
                begin
                    next_st.irq_mask = wd[1:0];
                end
                default:
                begin
                end
            endcase
        end

        // Clocks and loop filter; registers are left alone while stopped
        if (!running)
        begin
            next_st.osc_clk = 1'b0;
            next_st.core_clk = 1'b0;
            next_st.base_clk = 1'b0;
            next_st.clk_ph = 2'h0;
            next_st.corr_cnt = 3'h0;
        end
        else
        begin
            if (dco_tick)
            begin
                next_st.osc_clk = !st.osc_clk;
                next_st.clk_ph = st.clk_ph + 2'h1;
                if (st.clk_ph == ict_pkg::CORE_LAST)
                begin
                    // Core clock is the oscillator clock over four
                    next_st.core_clk = !st.core_clk;
                end
            end
            if (base_tick)
            begin
                next_st.base_clk = !st.base_clk;
                next_st.corr_cnt = st.corr_cnt + 3'h1;
                if (st.corr_cnt == ict_pkg::CORR_LAST)
                begin
                    // One correction per four base periods
                    if (cmp.too_fast)
                    begin
                        if (st.stage == ict_pkg::STAGE_MAX)
                        begin
                            if (st.div != ict_pkg::DIV_MAX)
                            begin
                                next_st.div = st.div + 4'h1;
                                next_st.stage = ict_pkg::STAGE_MID;
                            end
                        end
                        else
                        begin
                            next_st.stage = st.stage + 8'h1;
                        end
                    end
                    else if (cmp.too_slow)
                    begin
                        if (st.stage == ict_pkg::STAGE_MID && st.div != 4'h0)
                        begin
                            next_st.div = st.div - 4'h1;
                            next_st.stage = ict_pkg::STAGE_MAX;
                        end
                        else if (st.stage != ict_pkg::STAGE_MIN)
                        begin
                            next_st.stage = st.stage - 8'h1;
                        end
                    end
                    if (cmp.within5 && !st.stable)
                    begin
                        next_st.stable = 1'b1;
                        ev[ict_pkg::EV_STABLE] = 1'b1;
                    end
                end
            end
        end

        // Forced clears win over the filter setting the flag
        if (!st.gen_on || cmp.int_inactive || (st.wr_pend && st.wr_addr == ict_pkg::A_MULT))
        begin
            next_st.stable = 1'b0;
            ev[ict_pkg::EV_STABLE] = 1'b0;
        end
        ev[ict_pkg::EV_INACT] = cmp.int_inactive;

        // A new event wins over a write-one clear in the same cycle
        next_st.irq_stat = (st.irq_stat & ~clr) | ev;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

        // Trim only switches capacitor units; frequency shift is analog
        next_st.cap = ict_pkg::CAP_FIXED + {2'h0, next_st.trim};
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.gen_on <= ict_pkg::GEN_ON_RST;
            st.slow_opt <= ict_pkg::SLOW_RST;
            st.mult <= ict_pkg::MULT_RST;
            st.trim <= ict_pkg::TRIM_RST;
            st.div <= ict_pkg::DIV_RST;
            st.stage <= ict_pkg::STAGE_RST;
            st.cap <= ict_pkg::CAP_RST;
            st.rdy <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign ahb_rsp.hreadyout = st.rdy;
    assign ahb_rsp.hresp = 1'b0;
    assign ahb_rsp.hrdata = st.rdata;
    assign osc_output_clock = st.osc_clk;
    assign low_freq_base_clock = st.base_clk;
    assign core_output_clock = st.core_clk;
    assign cap_units = st.cap;
    assign amp_low_drive = st.slow_opt;
    assign mon_expect_slow = st.slow_opt;
    assign internal_gen_stable = st.stable;
    assign irq = st.irq;

    sequence s_div_wr_locked;
        st.wr_pend && st.wr_addr == ict_pkg::A_DIV && st.gen_on;
    endsequence

    sequence s_stage_wr_open;
        st.wr_pend && st.wr_addr == ict_pkg::A_STAGE && !st.gen_on;
    endsequence

    sequence s_stop_entry;
        !stop_mode ##1 stop_mode;
    endsequence

    a_div_locked: assert property (@(posedge clk) disable iff (sys_rst)
        s_div_wr_locked and !(running && base_tick) |=> st.div == $past(st.div))
        else $error("divider changed by write while generator on");

    a_stage_load: assert property (@(posedge clk) disable iff (sys_rst)
        s_stage_wr_open |=> st.stage == $past(ahb_req.hwdata[7:0]))
        else $error("stage write while off not taken");

    a_stop_low: assert property (@(posedge clk) disable iff (sys_rst)
        s_stop_entry |=> !osc_output_clock && !core_output_clock && !low_freq_base_clock)
        else $error("clocks not held low in stop");

    a_stop_keep: assert property (@(posedge clk) disable iff (sys_rst)
        stop_mode && !st.wr_pend |=> $stable(st.div) && $stable(st.stage) && $stable(st.trim))
        else $error("register changed during stop");

    a_cap_units: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 cap_units == ict_pkg::CAP_FIXED + {2'h0, st.trim})
        else $error("capacitor units do not follow trim");

    a_slow_write: assert property (@(posedge clk) disable iff (sys_rst)
        st.wr_pend && st.wr_addr == ict_pkg::A_CTRL
        |=> amp_low_drive == $past(ahb_req.hwdata[1]) && mon_expect_slow == amp_low_drive)
        else $error("slow option not applied");

    a_stable_clr: assert property (@(posedge clk) disable iff (sys_rst)
        cmp.int_inactive || !st.gen_on |=> !internal_gen_stable)
        else $error("stable flag not forced clear");

    a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        irq == |(st.irq_stat & st.irq_mask))
        else $error("interrupt output disagrees with status and mask");

    a_core_div: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(core_output_clock) && running |-> $past(dco_tick) && $past(st.clk_ph) == 2'h3)
        else $error("core clock not a quarter of oscillator clock");

endmodule

// ===== sim/ict_src_model.sv
// Purpose: Comparator side model that judges the oscillator half period
// Assumes: Bench sets the target half period in clk cycles, 0 keeps it quiet
// Notes: Verdict holds between edges; inactivity is only what the bench commands
`timescale 1ns/10ps

module ict_src_model (
    input wire logic clk, // System clock
    input wire logic osc, // Oscillator clock under judgement
    input wire logic inact, // Commanded internal inactivity
    input wire logic [15:0] tgt, // Target half period
    output ict_pkg::ict_cmp_t cmp // Comparator verdict
);
    int n = 0;
    int t;
    int d;
    logic last = 1'b0;

    always_comb t = int'(tgt);
    always_comb d = (n > t) ? n - t : t - n;

    // Long gaps after a restart are not measurements, so they are skipped
    always @(posedge clk)
    begin
        last <= osc;
        n <= (osc != last) ? 1 : n + 1;
        if (osc != last && t != 0 && n <= 4 * t)
        begin
            cmp.too_fast <= n < t;
            cmp.too_slow <= n > t;
            cmp.within5 <= 20 * d <= t;
        end
        cmp.int_inactive <= inact;
    end

    initial cmp = '0;
endmodule

// ===== sim/ict_top_tb.sv
// Purpose: Self-checking bench for the clock generator tuning block
// Assumes: Zero wait state slave, comparator model on the oscillator clock
// Notes: Read results are queued by the bus task and judged by a monitor
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module ict_top_tb;
    logic clk;
    logic sys_rst;
    ict_pkg::ict_ahb_req_t drv;
    ict_pkg::ict_ahb_req_t bq;
    ict_pkg::ict_ahb_rsp_t rsp;
    ict_pkg::ict_cmp_t cmp;
    logic stop_mode, osc, base, core, amp, mslow, stab, irq, inact, rd_on, acc;
    logic [9:0] cap;
    logic [15:0] tgt;
    logic [31:0] expq[$];
    logic [31:0] e;
    logic [7:0] r;
    int num_errors = 0;
    int checked = 0;
    int c;

    ict_top #(.PER_SHIFT(4)) ict_top_i (.clk(clk), .sys_rst(sys_rst), .ahb_req(bq),
        .ahb_rsp(rsp), .cmp(cmp), .stop_mode(stop_mode), .osc_output_clock(osc),
        .low_freq_base_clock(base), .core_output_clock(core), .cap_units(cap),
        .amp_low_drive(amp), .mon_expect_slow(mslow), .internal_gen_stable(stab),
        .irq(irq));
    ict_src_model ict_src_model_i (.clk(clk), .osc(osc), .inact(inact), .tgt(tgt),
        .cmp(cmp));

    always_comb
    begin
        bq = drv;
        bq.hready = rsp.hreadyout;
    end

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
        if (rd_on === 1'b1)
        begin
            e = expq.pop_front();
            `CHK("hrdata", e, rsp.hrdata)
        end

    function automatic logic pick(input int s);
        return s == 0 ? osc : (s == 1 ? core : base);
    endfunction

    task automatic results();
        $display("counts: %0d checks, %0d mismatches", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic hwait();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp.hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            num_errors++;
            results();
        end
    endtask

    // For a read, d is the value expected back
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w)
            expq.push_back(d);
        drv.hsel <= 1'b1;
        drv.htrans <= 2'b10;
        drv.haddr <= {24'h0, a};
        drv.hwrite <= w;
        drv.hsize <= 3'h2;
        hwait();
        drv.hsel <= 1'b0;
        drv.htrans <= 2'b00;
        drv.hwdata <= d;
        rd_on <= !w;
        hwait();
        rd_on <= 1'b0;
    endtask

    // Edges between two changes of the chosen clock
    task automatic per(input int s, output int n);
        logic v;
        repeat (2)
        begin
            v = pick(s);
            n = 0;
            while (pick(s) === v && n < 5000)
            begin
                @(posedge clk);
                n++;
            end
        end
        if (n >= 5000)
        begin
            num_errors++;
            results();
        end
    endtask

    // Bounded wait for the filter to report lock
    task automatic wait_stable();
        int n;
        n = 0;
        while (stab !== 1'b1 && n < 4000)
        begin
            @(posedge clk);
            n++;
        end
        `CHK("stable set", 1'b1, stab)
    endtask

    initial
    begin
        drv = '0;
        stop_mode = 1'b0;
        inact = 1'b0;
        rd_on = 1'b0;
        tgt = 16'd16;
        acc = 1'b0;
        sys_rst = 1'b1;
        r = 8'($urandom(32'h42d911d8));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        `CHK("cap", 10'h200, cap)
        `CHK("amp", 1'b0, amp)
        `CHK("mslow", 1'b0, mslow)
        `CHK("stable", 1'b0, stab)
        bus(0, ict_pkg::A_CTRL, 32'h1);
        bus(0, ict_pkg::A_MULT, 32'h15);
        bus(0, ict_pkg::A_TRIM, 32'h80);
        bus(0, ict_pkg::A_IRQS, 32'h0);
        bus(0, ict_pkg::A_IRQM, 32'h0);
        bus(0, 8'h40, 32'h0);
        bus(1, ict_pkg::A_DIV, 32'h3);
        bus(1, ict_pkg::A_STAGE, 32'h22);
        bus(0, ict_pkg::A_DIV, 32'h1);
        bus(0, ict_pkg::A_STAGE, 32'h80);
        per(0, c);
        `CHK("osc half", 32'd16, c)
        $display("end: reset and locked writes");
        wait_stable();
        bus(1, ict_pkg::A_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("stable off", 1'b0, stab)
        bus(1, ict_pkg::A_DIV, 32'h0);
        bus(1, ict_pkg::A_STAGE, 32'h40);
        bus(0, ict_pkg::A_DIV, 32'h0);
        bus(0, ict_pkg::A_STAGE, 32'h40);
        tgt <= 16'd4;
        bus(1, ict_pkg::A_CTRL, 32'h1);
        per(0, c);
        `CHK("preset half", 32'd4, c)
        per(1, c);
        `CHK("core half", 32'd16, c)
        bus(1, ict_pkg::A_MULT, 32'h2);
        per(2, c);
        `CHK("base half", 32'd8, c)
        wait_stable();
        bus(1, ict_pkg::A_MULT, 32'h2);
        @(posedge clk);
        `CHK("stable mult", 1'b0, stab)
        $display("end: preset and clock ratios");
        for (int i = 0; i < 4; i++)
        begin
            r = (i == 0) ? 8'h00 : ((i == 1) ? 8'hff : 8'($urandom));
            bus(1, ict_pkg::A_TRIM, {24'h0, r});
            repeat (2) @(posedge clk);
            `CHK("cap", 10'h180 + 10'(r), cap)
            bus(0, ict_pkg::A_TRIM, {24'h0, r});
        end
        $display("end: trim");
        bus(1, ict_pkg::A_CTRL, 32'h3);
        repeat (2) @(posedge clk);
        `CHK("amp", 1'b1, amp)
        `CHK("mslow", 1'b1, mslow)
        bus(1, ict_pkg::A_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("amp", 1'b0, amp)
        `CHK("mslow", 1'b0, mslow)
        $display("end: slow option");
        stop_mode <= 1'b1;
        repeat (2) @(posedge clk);
        repeat (40)
        begin
            @(posedge clk);
            acc = acc | osc | core | base;
        end
        `CHK("clocks stopped", 1'b0, acc)
        bus(0, ict_pkg::A_DIV, 32'h0);
        bus(0, ict_pkg::A_STAGE, 32'h40);
        bus(0, ict_pkg::A_MULT, 32'h2);
        bus(0, ict_pkg::A_TRIM, {24'h0, r});
        stop_mode <= 1'b0;
        per(0, c);
        `CHK("resume half", 32'd4, c)
        $display("end: stop mode");
        wait_stable();
        bus(1, ict_pkg::A_IRQS, 32'h3);
        bus(1, ict_pkg::A_IRQM, 32'h2);
        // Inactivity still asserted when the flag is looked at, so no lock can re-set it
        inact <= 1'b1;
        repeat (3) @(posedge clk);
        inact <= 1'b0;
        `CHK("irq", 1'b1, irq)
        `CHK("stable inact", 1'b0, stab)
        bus(1, ict_pkg::A_IRQS, 32'h2);
        repeat (2) @(posedge clk);
        `CHK("irq clear", 1'b0, irq)
        bus(1, ict_pkg::A_IRQM, 32'h0);
        inact <= 1'b1;
        @(posedge clk);
        inact <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        $display("end: interrupt");
        results();
    end
endmodule
